//--- common/uie_cfg.svh
// Summary of operation
// R1: FIFO mode with receive enable: data request follows fill at or above trigger.
// R2: Status register shows receive trigger while reached, cleared with the request.
// R3: Data-ready status bit sets when a character enters the receive FIFO, clears empty.
// R4: FIFO on and enable bits 0-3 clear gives polled mode on status bits.
// R5: Status bit 1 reports a receive overrun.
// R6: Status bits 2-4 give the error kind of the character at the head.
// R7: Status bit 5 is set while transmit holding register or FIFO is empty.
// R8: Status bit 6 is set only when transmit FIFO and shifter are empty.
// R9: Status bit 7 is set while any stored receive character has an error.
// R10: Enable bit 0 gates the receive data request; resets disabled.
// R11: Enable bit 1 gates transmit-ready; empty or below trigger raises it.
// R12: Enabling transmit-ready while transmit side is empty raises it at once.
// R13: Enable bit 2 gates the line status request from status bits 1-4.
// R14: Overrun raises the line status request immediately.
// R15: By default errors raise the request when the character reaches the head.
// R16: Error-at-entry mode raises the request as the bad character enters.
// R17: Enable bit 3 gates the modem status request; resets disabled.
// R18: Enables only mask; requests are reported in the status register. The code reports only enabled requests there.
// R19: FIFO control bit 0 enables both FIFOs; zero selects non-FIFO mode.
// R20: Reading the line status register clears a pending line status request.
// R21: Status register read or holding register write clears transmit-ready.
// R22: Modem request is raised when any modem status bit 0-3 is set.
// R23: One interrupt output is high while any enabled source is pending.
`ifndef UIE_CFG_SVH
`define UIE_CFG_SVH

`define UIE_OFS_DATA     3'h0
`define UIE_OFS_IER      3'h1
`define UIE_OFS_ISR_FCR  3'h2
`define UIE_OFS_LSR      3'h5
`define UIE_OFS_MSR      3'h6
`define UIE_OFS_XOFF_CHAR_FIRST    3'h6
`define UIE_OFS_XOFF_CHAR_SECOND    3'h7

`define UIE_IER_RST      8'h00
`define UIE_XOFF_RST     8'h00
`define UIE_BYTE_ZERO    8'h00

`define UIE_IER_RXD      0
`define UIE_IER_TXR      1
`define UIE_IER_LSR      2
`define UIE_IER_MSR      3
`define UIE_FCR_EN       0
`define UIE_FCR_RXRST    1
`define UIE_FCR_TXRST    2

`define UIE_ISR_LSR      4'h6
`define UIE_ISR_RXD      4'h4
`define UIE_ISR_TXR      4'h2
`define UIE_ISR_MSR      4'h0
`define UIE_ISR_NONE     4'h1

`define UIE_RX_DEPTH     16
`define UIE_CNT_W        5

`endif

//--- common/uie_pkg.sv
package uie_pkg;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_LSR,
    SRC_RXD,
    SRC_TXR,
    SRC_MSR
  } uie_src_t;

  typedef logic [7:0] uie_byte_t;

endpackage

//--- src/uie_err_fifo.sv
`timescale 1ns/10ps
`include "uie_cfg.svh"
// Shadow of the receive FIFO holding only the error flags of each entry.
// DEPTH must be a power of two so the pointers wrap by themselves.
module uie_err_fifo #(
  parameter int DEPTH = `UIE_RX_DEPTH,
  parameter int EW    = 3,
  parameter int CW    = `UIE_CNT_W
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire logic          flush_i,
  input  wire logic          push_i,
  input  wire logic [EW-1:0] push_err_i,
  input  wire logic          pop_i,
  output logic      [EW-1:0] head_err_o,
  output logic               any_err_o,
  output logic      [CW-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);

  logic [EW-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] bad_cnt_r;

  wire full     = (count_r == CW'(DEPTH));
  wire empty    = (count_r == '0);
  wire push_ok  = push_i & ~full;
  wire pop_ok   = pop_i & ~empty;
  wire bad_push = push_ok & (|push_err_i);
  wire bad_pop  = pop_ok & (|mem_r[rd_ptr_r]);

  always_ff @(posedge clk_sys_i) begin
    if (push_ok) begin
      mem_r[wr_ptr_r] <= push_err_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      bad_cnt_r <= '0;
    end else if (flush_i) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      bad_cnt_r <= '0;
    end else begin
      wr_ptr_r  <= wr_ptr_r + AW'(push_ok);
      rd_ptr_r  <= rd_ptr_r + AW'(pop_ok);
      count_r   <= count_r + CW'(push_ok) - CW'(pop_ok);
      bad_cnt_r <= bad_cnt_r + CW'(bad_push) - CW'(bad_pop);
    end
  end

  assign head_err_o = empty ? '0 : mem_r[rd_ptr_r];  // [R6]
  assign any_err_o  = (bad_cnt_r != '0);             // [R9]
  assign count_o    = count_r;

endmodule

//--- src/uie_top.sv
`timescale 1ns/10ps
`include "uie_cfg.svh"
module uie_top #(
  parameter int RX_DEPTH = `UIE_RX_DEPTH,
  parameter int CW       = `UIE_CNT_W
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire logic          cs_i,
  input  wire logic          rd_i,
  input  wire logic          wr_i,
  input  wire logic [2:0]    addr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          enh_bank_i,
  input  wire logic          err_at_entry_i,
  input  wire logic [7:0]    rhr_data_i,
  input  wire logic [7:0]    msr_data_i,
  input  wire logic          rx_push_i,
  input  wire logic [2:0]    rx_push_err_i,
  input  wire logic          rx_overrun_i,
  input  wire logic [CW-1:0] rx_trig_i,
  input  wire logic [CW-1:0] tx_fill_i,
  input  wire logic [CW-1:0] tx_trig_i,
  input  wire logic          tsr_empty_i,
  input  wire logic [3:0]    modem_delta_i,
  output logic               irq_o,
  output logic      [7:0]    rdata_o,
  output logic               rhr_rd_o,
  output logic               thr_wr_o,
  output logic               msr_rd_o,
  output logic               rx_flush_o,
  output logic               tx_flush_o,
  output logic               fifo_en_o,
  output logic      [7:0]    xoff_char_first_o,
  output logic      [7:0]    xoff_char_second_o,
  output logic      [CW-1:0] rx_count_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0]        interrupt_enable_mask_r;
  logic              fifo_en_r;
  logic [7:0]        xoff_char_first_r;
  logic [7:0]        xoff_char_second_r;
  logic [7:0]        rdata_r;
  logic              overrun_r;
  logic              lsr_pend_r;
  logic              tx_pend_r;
  logic              tx_cond_r;
  logic              head_new_r;
  logic              irq_r;
  logic              rhr_rd_r;
  logic              thr_wr_r;
  logic              msr_rd_r;
  logic              rx_flush_r;
  logic              tx_flush_r;

  logic [2:0]        head_err;
  logic              any_err;
  logic [CW-1:0]     rx_count;
  uie_pkg::uie_src_t src;
  logic [3:0]        isr_code;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire acc_rd     = cs_i & rd_i;
  wire acc_wr     = cs_i & wr_i;
  wire norm_bank  = ~enh_bank_i;
  wire sel_data   = norm_bank & (addr_i == `UIE_OFS_DATA);
  wire sel_ier    = norm_bank & (addr_i == `UIE_OFS_IER);
  wire sel_isr    = norm_bank & (addr_i == `UIE_OFS_ISR_FCR);
  wire sel_lsr    = norm_bank & (addr_i == `UIE_OFS_LSR);
  wire sel_msr    = norm_bank & (addr_i == `UIE_OFS_MSR);
  wire sel_xoff_char_first  = enh_bank_i & (addr_i == `UIE_OFS_XOFF_CHAR_FIRST);
  wire sel_xoff_char_second  = enh_bank_i & (addr_i == `UIE_OFS_XOFF_CHAR_SECOND);

  wire ier_wr     = acc_wr & sel_ier;
  wire fcr_wr     = acc_wr & sel_isr;
  wire thr_wr     = acc_wr & sel_data;
  wire isr_rd     = acc_rd & sel_isr;
  wire lsr_rd     = acc_rd & sel_lsr;
  wire msr_rd     = acc_rd & sel_msr;
  wire rx_empty   = (rx_count == '0);
  wire rhr_pop    = acc_rd & sel_data & ~rx_empty;

  // FIFO reset bits only act together with the enable bit
  wire fcr_en_bit = wdata_i[`UIE_FCR_EN];
  wire rx_flush   = fcr_wr & fcr_en_bit & wdata_i[`UIE_FCR_RXRST];
  wire tx_flush   = fcr_wr & fcr_en_bit & wdata_i[`UIE_FCR_TXRST];

  wire ier_rxd    = interrupt_enable_mask_r[`UIE_IER_RXD];
  wire ier_txr    = interrupt_enable_mask_r[`UIE_IER_TXR];
  wire ier_lsr    = interrupt_enable_mask_r[`UIE_IER_LSR];
  wire ier_msr    = interrupt_enable_mask_r[`UIE_IER_MSR];

  //////////////////////////////////////////////////////////////////////////////
  // Receive error shadow

  uie_err_fifo #(
    .DEPTH      (RX_DEPTH),
    .EW         (3),
    .CW         (CW)
  ) u_err_fifo (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .flush_i    (rx_flush),
    .push_i     (rx_push_i),
    .push_err_i (rx_push_err_i),
    .pop_i      (rhr_pop),
    .head_err_o (head_err),
    .any_err_o  (any_err),
    .count_o    (rx_count)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Line status

  wire rx_full     = (rx_count == CW'(RX_DEPTH));
  wire tx_empty    = (tx_fill_i == '0);
  wire lsr_dr      = ~rx_empty;                      // [R3]
  wire lsr_thre    = tx_empty;                       // [R7]
  wire lsr_temt    = tx_empty & tsr_empty_i;         // [R8]
  wire lsr_fifoerr = any_err;                        // [R9]
  wire [7:0] lsr_val = {lsr_fifoerr, lsr_temt, lsr_thre,
                        head_err, overrun_r, lsr_dr}; // [R5] [R6] [R4]

  // Head changes when a char lands in an empty FIFO or a pop exposes the next
  wire head_new  = (rx_push_i & rx_empty & ~rx_flush)
                 | (rhr_pop & ((rx_count > CW'(1)) | rx_push_i));
  wire bad_entry = rx_push_i & ~rx_full & (|rx_push_err_i);
  wire err_event = err_at_entry_i ? bad_entry              // [R16]
                                  : (head_new_r & (|head_err)); // [R15]
  wire lsr_set   = rx_overrun_i | err_event;          // [R14] [R13]

  //////////////////////////////////////////////////////////////////////////////
  // Request sources

  // Non-FIFO mode behaves as a one-deep FIFO: any character is a trigger
  wire rx_cond  = fifo_en_r ? (rx_count >= rx_trig_i) : ~rx_empty; // [R1]
  wire tx_cond  = fifo_en_r ? (tx_fill_i < tx_trig_i) : tx_empty;  // [R11]
  wire ier_txr_rise = ier_wr & wdata_i[`UIE_IER_TXR] & ~ier_txr;
  wire tx_set   = tx_cond & ((~tx_cond_r & ier_txr) | ier_txr_rise); // [R12]
  wire tx_clr   = isr_rd | thr_wr;                                   // [R21]

  wire rx_req   = ier_rxd & rx_cond;                  // [R10] [R1]
  wire tx_req   = ier_txr & tx_pend_r;                // [R11]
  wire lsr_req  = ier_lsr & lsr_pend_r;               // [R13]
  wire msr_req  = ier_msr & (|modem_delta_i);         // [R17] [R22]

  // Fixed priority: line status, receive data, transmit, modem
  assign src = lsr_req ? uie_pkg::SRC_LSR :
               rx_req  ? uie_pkg::SRC_RXD :
               tx_req  ? uie_pkg::SRC_TXR :
               msr_req ? uie_pkg::SRC_MSR : uie_pkg::SRC_NONE;  // [R18]

  always_comb begin
    unique case (src)
      uie_pkg::SRC_LSR:  isr_code = `UIE_ISR_LSR;
      uie_pkg::SRC_RXD:  isr_code = `UIE_ISR_RXD;      // [R2]
      uie_pkg::SRC_TXR:  isr_code = `UIE_ISR_TXR;
      uie_pkg::SRC_MSR:  isr_code = `UIE_ISR_MSR;
      uie_pkg::SRC_NONE: isr_code = `UIE_ISR_NONE;
      default:           isr_code = `UIE_ISR_NONE;
    endcase
  end

  wire [7:0] isr_val = {fifo_en_r, fifo_en_r, 2'h0, isr_code}; // [R18]
  wire       irq_nxt = (src != uie_pkg::SRC_NONE);            // [R23] [R4]

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [7:0] rdata_nxt =
      (sel_data)  ? rhr_data_i :
      (sel_ier)   ? interrupt_enable_mask_r :
      (sel_isr)   ? isr_val :
      (sel_lsr)   ? lsr_val :
      (sel_msr)   ? msr_data_i :
      (sel_xoff_char_first) ? xoff_char_first_r :
      (sel_xoff_char_second) ? xoff_char_second_r : `UIE_BYTE_ZERO;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_enable_mask_r <= `UIE_IER_RST;       // [R10] [R17]
      fifo_en_r               <= 1'b0;               // [R19]
      xoff_char_first_r       <= `UIE_XOFF_RST;
      xoff_char_second_r      <= `UIE_XOFF_RST;
    end else begin
      if (ier_wr) begin
        interrupt_enable_mask_r <= wdata_i;
      end
      if (fcr_wr) begin
        fifo_en_r <= fcr_en_bit;                     // [R19]
      end
      if (acc_wr & sel_xoff_char_first) begin
        xoff_char_first_r <= wdata_i;
      end
      if (acc_wr & sel_xoff_char_second) begin
        xoff_char_second_r <= wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status; a set in the clearing cycle wins

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_r  <= 1'b0;
      lsr_pend_r <= 1'b0;
      tx_pend_r  <= 1'b0;
      tx_cond_r  <= 1'b0;
      head_new_r <= 1'b0;
    end else begin
      overrun_r  <= rx_overrun_i | (overrun_r & ~lsr_rd);   // [R5]
      lsr_pend_r <= lsr_set | (lsr_pend_r & ~lsr_rd);       // [R20]
      tx_pend_r  <= tx_set | (tx_pend_r & ~tx_clr);         // [R21]
      tx_cond_r  <= tx_cond;
      head_new_r <= head_new;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_r      <= 1'b0;
      rdata_r    <= `UIE_BYTE_ZERO;
      rhr_rd_r   <= 1'b0;
      thr_wr_r   <= 1'b0;
      msr_rd_r   <= 1'b0;
      rx_flush_r <= 1'b0;
      tx_flush_r <= 1'b0;
    end else begin
      irq_r      <= irq_nxt;                               // [R23]
      rhr_rd_r   <= rhr_pop;
      thr_wr_r   <= thr_wr;
      msr_rd_r   <= msr_rd;
      rx_flush_r <= rx_flush;
      tx_flush_r <= tx_flush;
      if (acc_rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign irq_o              = irq_r;
  assign rdata_o            = rdata_r;
  assign rhr_rd_o           = rhr_rd_r;
  assign thr_wr_o           = thr_wr_r;
  assign msr_rd_o           = msr_rd_r;
  assign rx_flush_o         = rx_flush_r;
  assign tx_flush_o         = tx_flush_r;
  assign fifo_en_o          = fifo_en_r;
  assign xoff_char_first_o  = xoff_char_first_r;
  assign xoff_char_second_o = xoff_char_second_r;
  assign rx_count_o         = rx_count;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_RX_TRIG: assert property ( // [R1]
    (fifo_en_r && ier_rxd && rx_count >= rx_trig_i) |=> irq_r)
    else $error("receive trigger did not raise the interrupt");

  AST_ISR_RXD: assert property ( // [R2]
    (isr_rd && rx_req && !lsr_req) |=> (rdata_r[3:0] == `UIE_ISR_RXD))
    else $error("status register did not show receive trigger");

  AST_DATA_READY: assert property ( // [R3]
    (rx_push_i && !rx_flush && !rhr_pop) |=> lsr_val[0])
    else $error("data ready not set after character arrival");

  AST_POLLED: assert property ( // [R4]
    (interrupt_enable_mask_r[3:0] == 4'h0) |=> !irq_r)
    else $error("interrupt raised with all sources masked");

  AST_OVERRUN: assert property ( // [R5]
    rx_overrun_i |=> (overrun_r && lsr_pend_r))
    else $error("overrun not recorded at once");

  AST_TEMT_THRE: assert property ( // [R8]
    lsr_val[6] |-> (lsr_val[5] && tsr_empty_i))
    else $error("transmitter empty without holding register empty");

  AST_TX_ENABLE: assert property ( // [R12]
    (ier_txr_rise && tx_cond) |=> tx_pend_r)
    else $error("enabling transmit-ready on empty did not raise it");

  AST_TX_CLEAR: assert property ( // [R21]
    (tx_clr && !tx_set) |=> !tx_pend_r)
    else $error("transmit-ready not cleared");

  AST_LSR_CLEAR: assert property ( // [R20]
    (lsr_rd && !lsr_set) |=> (!lsr_pend_r && !overrun_r))
    else $error("line status read did not clear the request");

  AST_MODEM: assert property ( // [R22]
    (ier_msr && (|modem_delta_i)) |=> irq_r)
    else $error("modem change with enable did not interrupt");

  AST_ERR_ENTRY: assert property ( // [R16]
    (err_at_entry_i && bad_entry) |=> lsr_pend_r)
    else $error("error at entry did not raise line status");

endmodule

//--- verification/uie_host_model.sv
`timescale 1ns/10ps
// Host processor on the parallel register bus: one access at a time,
// launched just after an edge and held until the taking edge.
module uie_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rdata_i,
  output logic            cs_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [2:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    {cs_o, rd_o, wr_o} = 3'h0;
    addr_o  = 3'h0;
    wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    cs_o    <= 1'h1;
    wr_o    <= 1'h1;
    addr_o  <= a;
    wdata_o <= v;
    @(posedge clk_sys_i);
    cs_o    <= 1'h0;
    wr_o    <= 1'h0;
    // Released data must not keep looking valid
    wdata_o <= ~v;
  endtask

  // Status is polled with plain reads, no interrupt needed
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    cs_o   <= 1'h1;
    rd_o   <= 1'h1;
    addr_o <= a;
    @(posedge clk_sys_i);
    cs_o   <= 1'h0;
    rd_o   <= 1'h0;
    addr_o <= ~a;
    #1 v = rdata_i;
  endtask
endmodule

//--- verification/uart_irq_enable_status_test.sv
`timescale 1ns/10ps
module uart_irq_enable_status_test;
  logic       clk_sys_i, rst_i, enh, ent, push, ovr, tsr_e;
  logic       cs, rd, wr, irq, fen;
  logic       rhr_rd, thr_wr, msr_rd, rxf, txf;
  logic [4:0] rxc;
  logic [2:0] push_err, addr;
  logic [4:0] rx_trig, tx_fill, tx_trig;
  logic [3:0] mdelta;
  logic [7:0] rhr_d, msr_d, rdata, wdata, x1, x2, d;
  int         n_fail, n_checks;

  uie_top i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_i(cs), .rd_i(rd),
    .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .enh_bank_i(enh),
    .err_at_entry_i(ent), .rhr_data_i(rhr_d), .msr_data_i(msr_d),
    .rx_push_i(push), .rx_push_err_i(push_err), .rx_overrun_i(ovr),
    .rx_trig_i(rx_trig), .tx_fill_i(tx_fill), .tx_trig_i(tx_trig),
    .tsr_empty_i(tsr_e), .modem_delta_i(mdelta), .irq_o(irq),
    .rdata_o(rdata), .rhr_rd_o(rhr_rd), .thr_wr_o(thr_wr),
    .msr_rd_o(msr_rd), .rx_flush_o(rxf), .tx_flush_o(txf),
    .fifo_en_o(fen), .xoff_char_first_o(x1),
    .xoff_char_second_o(x2), .rx_count_o(rxc)
  );

  uie_host_model i_host (
    .clk_sys_i(clk_sys_i), .rdata_i(rdata), .cs_o(cs), .rd_o(rd),
    .wr_o(wr), .addr_o(addr), .wdata_o(wdata)
  );

  initial begin
    clk_sys_i = 1'h0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Three edges covers the registered request plus its one-cycle output
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_sys_i);
    #1 chk({7'h00, irq}, {7'h00, e}, "irq level");
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e,
                        input string m);
    i_host.rd_reg(a, d);
    chk(d, e, m);
  endtask

  task automatic push_c(input logic [2:0] e);
    @(posedge clk_sys_i);
    push     <= 1'h1;
    push_err <= e;
    @(posedge clk_sys_i);
    push     <= 1'h0;
    push_err <= ~e;
  endtask

  task automatic pulse_ovr;
    @(posedge clk_sys_i);
    ovr <= 1'h1;
    @(posedge clk_sys_i);
    ovr <= 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(3'h1, 8'h00, "mask reset");
    rd_chk(3'h2, 8'h01, "isr reset");
    chk({7'h00, fen}, 8'h00, "fifo off");
  endtask

  task automatic t_xoff;
    @(posedge clk_sys_i);
    enh <= 1'h1;
    i_host.wr_reg(3'h6, 8'hA5);
    i_host.wr_reg(3'h7, 8'h3C);
    // Mask offset is unmapped in this bank, write must vanish
    i_host.wr_reg(3'h1, 8'hFF);
    rd_chk(3'h6, 8'hA5, "xoff first");
    rd_chk(3'h7, 8'h3C, "xoff second");
    rd_chk(3'h1, 8'h00, "unmapped");
    chk(x1, 8'hA5, "xoff first out");
    chk(x2, 8'h3C, "xoff second out");
    @(posedge clk_sys_i);
    enh <= 1'h0;
    rd_chk(3'h1, 8'h00, "mask kept");
  endtask

  task automatic t_rx_nonfifo;
    i_host.wr_reg(3'h1, 8'h01);
    push_c(3'h0);
    irq_is(1'h1);
    rd_chk(3'h2, 8'h04, "isr rx data");
    rd_chk(3'h0, 8'h5A, "rx data");
    chk({7'h00, rhr_rd}, 8'h01, "pop pulse");
    irq_is(1'h0);
  endtask

  task automatic t_rx_fifo;
    i_host.wr_reg(3'h2, 8'h01);
    rd_chk(3'h2, 8'hC1, "isr fifo on");
    chk({7'h00, fen}, 8'h01, "fifo on");
    repeat (3) push_c(3'h0);
    irq_is(1'h0);
    push_c(3'h0);
    irq_is(1'h1);
    chk({3'h0, rxc}, 8'h04, "rx count");
    rd_chk(3'h2, 8'hC4, "isr trigger");
    rd_chk(3'h5, 8'h01, "lsr ready");
    rd_chk(3'h0, 8'h5A, "pop");
    irq_is(1'h0);
    rd_chk(3'h2, 8'hC1, "isr below");
    repeat (3) rd_chk(3'h0, 8'h5A, "pop");
    rd_chk(3'h5, 8'h00, "lsr empty");
    rd_chk(3'h0, 8'h5A, "empty read");
    chk({7'h00, rhr_rd}, 8'h00, "no pop when empty");
    chk({3'h0, rxc}, 8'h00, "count empty");
    push_c(3'h0);
    i_host.wr_reg(3'h2, 8'h07);
    #1 chk({6'h00, rxf, txf}, 8'h03, "flush pulses");
    rd_chk(3'h5, 8'h00, "flushed");
  endtask

  task automatic t_line;
    i_host.wr_reg(3'h1, 8'h00);
    pulse_ovr();
    irq_is(1'h0);
    rd_chk(3'h5, 8'h02, "overrun");
    rd_chk(3'h5, 8'h00, "overrun read");
    i_host.wr_reg(3'h1, 8'h04);
    push_c(3'h2);
    irq_is(1'h1);
    rd_chk(3'h2, 8'hC6, "isr line");
    rd_chk(3'h5, 8'h89, "head error");
    irq_is(1'h0);
    pulse_ovr();
    irq_is(1'h1);
    rd_chk(3'h5, 8'h8B, "overrun data");
    push_c(3'h1);
    irq_is(1'h0);
    @(posedge clk_sys_i);
    ent <= 1'h1;
    push_c(3'h4);
    irq_is(1'h1);
    rd_chk(3'h5, 8'h89, "entry error");
    @(posedge clk_sys_i);
    ent <= 1'h0;
    i_host.wr_reg(3'h1, 8'h00);
    repeat (3) rd_chk(3'h0, 8'h5A, "pop");
    rd_chk(3'h5, 8'h00, "errors gone");
  endtask

  task automatic t_tx;
    @(posedge clk_sys_i);
    tx_fill <= 5'h00;
    rd_chk(3'h5, 8'h20, "tx empty");
    @(posedge clk_sys_i);
    tsr_e <= 1'h1;
    rd_chk(3'h5, 8'h60, "tx idle");
    i_host.wr_reg(3'h1, 8'h02);
    irq_is(1'h1);
    rd_chk(3'h2, 8'hC2, "isr tx");
    irq_is(1'h0);
    @(posedge clk_sys_i);
    tx_fill <= 5'h05;
    tsr_e   <= 1'h0;
    irq_is(1'h0);
    @(posedge clk_sys_i);
    tx_fill <= 5'h01;
    irq_is(1'h1);
    i_host.wr_reg(3'h0, 8'h77);
    #1 chk({7'h00, thr_wr}, 8'h01, "thr write pulse");
    irq_is(1'h0);
    i_host.wr_reg(3'h1, 8'h00);
  endtask

  task automatic t_modem;
    i_host.wr_reg(3'h1, 8'h08);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      mdelta <= 4'(4'h1 << i);
      irq_is(1'h1);
    end
    rd_chk(3'h2, 8'hC0, "isr modem");
    rd_chk(3'h6, 8'hC3, "modem read");
    chk({7'h00, msr_rd}, 8'h01, "modem read pulse");
    i_host.wr_reg(3'h1, 8'h00);
    irq_is(1'h0);
    @(posedge clk_sys_i);
    mdelta <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'h1;
    {enh, ent, push, ovr, tsr_e} = 5'h00;
    {rhr_d, msr_d} = 16'h5AC3;
    push_err = 3'h0;
    rx_trig  = 5'h04;
    tx_fill  = 5'h05;
    tx_trig  = 5'h02;
    mdelta   = 4'h0;
    n_fail   = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    t_reset();
    t_xoff();
    t_rx_nonfifo();
    t_rx_fifo();
    t_line();
    t_tx();
    t_modem();
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles; allow twenty thousand
  initial begin
    #2000000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
